// *** pmt_top.sv ***
// period match timer: apb registers, count/period compare, postscaler and interrupt
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module pmt_top #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	output logic                   match_pulse,
	output logic                   period_pulse
);
	import pmt_pkg::*;

	localparam int FLG_N = `PMT_FLG_COUNT;

	pmt_scale_if sc ();

	pmt_bus_state_t        bus_q;
	pmt_byte_t             control_q;
	pmt_byte_t             count_q;
	pmt_byte_t             period_q;
	logic [FLG_N-1:0]      flags_q;
	logic [FLG_N-1:0]      mask_q;
	logic [1:0]            iclk_q;
	logic [3:0]            post_q;
	logic [31:0]           prdata_q;
	logic                  pready_q;
	logic                  pslverr_q;
	logic                  irq_q;
	logic                  match_q;
	logic                  period_q_pulse;

	logic                  sel_ctl;
	logic                  sel_cnt;
	logic                  sel_per;
	logic                  sel_flg;
	logic                  sel_msk;
	logic                  mapped;
	logic                  fire;
	logic                  take;
	logic                  wr_byte;
	logic                  wr_ctl;
	logic                  wr_cnt;
	logic                  wr_per;
	logic                  wr_flg;
	logic                  wr_msk;
	logic                  run;
	logic                  iclk_tick;
	logic                  inc;
	logic                  hit;
	logic                  post_out;
	logic [3:0]            post_sel;
	logic [FLG_N-1:0]      flag_set;
	logic [31:0]           rd_data;

	// address decode, one aligned word per register
	assign sel_ctl = (paddr == ADDR_W'(`PMT_OFF_CONTROL));
	assign sel_cnt = (paddr == ADDR_W'(`PMT_OFF_COUNT));
	assign sel_per = (paddr == ADDR_W'(`PMT_OFF_PERIOD));
	assign sel_flg = (paddr == ADDR_W'(`PMT_OFF_FLAGS));
	assign sel_msk = (paddr == ADDR_W'(`PMT_OFF_MASK));
	assign mapped  = sel_ctl | sel_cnt | sel_per | sel_flg | sel_msk;

	// the edge that completes an access is the only one that writes a register
	assign fire    = (bus_q == PMT_BUS_ACK) && psel && penable;
	assign wr_byte = fire && pwrite && pstrb[0];
	assign wr_ctl  = wr_byte && sel_ctl;
	assign wr_cnt  = wr_byte && sel_cnt;
	assign wr_per  = wr_byte && sel_per;
	assign wr_flg  = wr_byte && sel_flg;
	assign wr_msk  = wr_byte && sel_msk;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= PMT_BUS_IDLE;
		end else begin
			case (bus_q)
				PMT_BUS_IDLE: begin
					if (psel && penable) begin
						bus_q <= PMT_BUS_ACK;
					end
				end
				PMT_BUS_ACK: begin
					bus_q <= PMT_BUS_IDLE;
				end
				default: begin
					bus_q <= PMT_BUS_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (sel_ctl) begin
			rd_data[7:0] = control_q & `PMT_CTL_IMPL_MASK;
		end else if (sel_cnt) begin
			rd_data[7:0] = count_q;
		end else if (sel_per) begin
			rd_data[7:0] = period_q;
		end else if (sel_flg) begin
			rd_data[FLG_N-1:0] = flags_q;
		end else if (sel_msk) begin
			rd_data[FLG_N-1:0] = mask_q;
		end
	end

	// the answer is prepared when an access is first seen, shown one cycle later
	assign take = (bus_q == PMT_BUS_IDLE) && psel && penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= take;
		end
	end

	// error only for addresses outside the map
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= take && !mapped;
		end
	end

	// read data stays zero outside the answer cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (take && !pwrite) begin
			prdata_q <= rd_data;
		end else begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// control register; bit 7 is not implemented and reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_q <= `PMT_RST_CONTROL;
		end else if (wr_ctl) begin
			control_q <= pwdata[7:0] & `PMT_CTL_IMPL_MASK;
		end
	end

	assign run      = control_q[`PMT_CTL_RUN_BIT];
	assign post_sel = control_q[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB];

	// any value with the upper select bit set maps to divide by 16
	always_comb begin
		if (control_q[`PMT_CTL_PRE_MSB]) begin
			sc.sel = PMT_PRE_16;
		end else if (control_q[`PMT_CTL_PRE_LSB]) begin
			sc.sel = PMT_PRE_4;
		end else begin
			sc.sel = PMT_PRE_1;
		end
	end

	// instruction clock: one tick every fourth pclk, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iclk_q <= 2'h0;
		end else begin
			iclk_q <= (iclk_q == 2'(`PMT_ICLK_DIV - 1)) ? 2'h0 : iclk_q + 2'h1;
		end
	end

	assign iclk_tick  = (iclk_q == 2'(`PMT_ICLK_DIV - 1));
	assign sc.tick_in = iclk_tick && run;
	assign sc.clear   = wr_cnt || wr_ctl;

	pmt_prescaler u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.sc      (sc.scaler)
	);

	// a tick that coincides with a count or control write is dropped with the write
	assign inc = sc.tick_out && !wr_cnt && !wr_ctl;
	assign hit = inc && (count_q == period_q);

	// count: software write wins; control writes never touch it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= `PMT_RST_COUNT;
		end else if (wr_cnt) begin
			count_q <= pwdata[7:0];
		end else if (hit) begin
			count_q <= 8'h00;
		end else if (inc) begin
			count_q <= count_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q <= `PMT_RST_PERIOD;
		end else if (wr_per) begin
			period_q <= pwdata[7:0];
		end
	end

	// postscaler counts matches and wraps at select plus one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_q <= 4'h0;
		end else if (sc.clear) begin
			post_q <= 4'h0;
		end else if (hit) begin
			post_q <= (post_q == post_sel) ? 4'h0 : post_q + 4'h1;
		end
	end

	assign post_out = hit && (post_q == post_sel);

	assign flag_set[`PMT_FLG_MATCH_BIT]  = hit;
	assign flag_set[`PMT_FLG_PERIOD_BIT] = post_out;

	// sticky flags, write one to clear; a set in the same cycle wins
	generate
		for (genvar i = 0; i < FLG_N; i++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flags_q[i] <= 1'b0;
				end else if (flag_set[i]) begin
					flags_q[i] <= 1'b1;
				end else if (wr_flg && pwdata[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `PMT_RST_MASK;
		end else if (wr_msk) begin
			mask_q <= pwdata[FLG_N-1:0];
		end
	end

	// irq lags the flag by a cycle so the output stays a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags_q & mask_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q_pulse <= 1'b0;
		end else begin
			period_q_pulse <= post_out;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign irq          = irq_q;
	assign match_pulse  = match_q;
	assign period_pulse = period_q_pulse;

endmodule

`default_nettype wire

// *** pmt_regs.svh ***
// register offsets, field positions, reset values and counts of the period match timer
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

`define PMT_OFF_CONTROL     12'h000
`define PMT_OFF_COUNT       12'h004
`define PMT_OFF_PERIOD      12'h008
`define PMT_OFF_FLAGS       12'h00C
`define PMT_OFF_MASK        12'h010

`define PMT_CTL_PRE_LSB     0
`define PMT_CTL_PRE_MSB     1
`define PMT_CTL_RUN_BIT     2
`define PMT_CTL_POST_LSB    3
`define PMT_CTL_POST_MSB    6
`define PMT_CTL_IMPL_MASK   8'h7F

`define PMT_FLG_MATCH_BIT   0
`define PMT_FLG_PERIOD_BIT  1
`define PMT_FLG_COUNT       2

`define PMT_RST_CONTROL     8'h00
`define PMT_RST_COUNT       8'h00
`define PMT_RST_PERIOD      8'hFF
`define PMT_RST_FLAGS       2'h0
`define PMT_RST_MASK        2'h0

`define PMT_ICLK_DIV        4
`define PMT_PRE_DIV_MID     4
`define PMT_PRE_DIV_HIGH    16

`endif

// *** pmt_pkg.sv ***
// types shared by the period match timer modules
`default_nettype none

package pmt_pkg;

	typedef enum logic [1:0] {
		PMT_BUS_IDLE = 2'b00,
		PMT_BUS_ACK  = 2'b01
	} pmt_bus_state_t;

	typedef enum logic [1:0] {
		PMT_PRE_1  = 2'b00,
		PMT_PRE_4  = 2'b01,
		PMT_PRE_16 = 2'b10
	} pmt_prescale_t;

	typedef logic [7:0] pmt_byte_t;

endpackage

`default_nettype wire

// *** pmt_scale_if.sv ***
// link between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none

interface pmt_scale_if;
	logic                   clear;
	pmt_pkg::pmt_prescale_t sel;
	logic                   tick_in;
	logic                   tick_out;

	modport core (
		output clear,
		output sel,
		output tick_in,
		input  tick_out
	);

	modport scaler (
		input  clear,
		input  sel,
		input  tick_in,
		output tick_out
	);
endinterface

`default_nettype wire

// *** pmt_prescaler.sv ***
// selectable 1, 4 or 16 prescaler on the instruction clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module pmt_prescaler (
	input  wire logic   pclk,
	input  wire logic   presetn,
	pmt_scale_if.scaler sc
);
	import pmt_pkg::*;

	logic [3:0] cnt_q;
	logic [3:0] last;

	always_comb begin
		case (sc.sel)
			PMT_PRE_1:  last = 4'h0;
			PMT_PRE_4:  last = 4'(`PMT_PRE_DIV_MID - 1);
			default:    last = 4'(`PMT_PRE_DIV_HIGH - 1);
		endcase
	end

	// clear restarts the division from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
		end else if (sc.clear) begin
			cnt_q <= 4'h0;
		end else if (sc.tick_in) begin
			cnt_q <= (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	assign sc.tick_out = sc.tick_in && (cnt_q >= last);

endmodule

`default_nettype wire

// *** pmt_checker.sv ***
// port-level assertions for the period match timer
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module pmt_checker #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              irq,
	input wire logic              match_pulse,
	input wire logic              period_pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ticks come every four clocks at the fastest
	sequence quiet3;
		!match_pulse [*3];
	endsequence
	sequence access_start;
		psel && $rose(penable);
	endsequence

	ready_wait_a: assert property (access_start |=> pready)
		else $error("no answer in second access cycle");
	ready_single_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_cause_a: assert property (pready |-> psel && penable)
		else $error("pready without access");
	err_mapped_a: assert property (pslverr |-> pready && !(paddr inside {
		ADDR_W'(`PMT_OFF_CONTROL), ADDR_W'(`PMT_OFF_COUNT), ADDR_W'(`PMT_OFF_PERIOD),
		ADDR_W'(`PMT_OFF_FLAGS), ADDR_W'(`PMT_OFF_MASK)}))
		else $error("pslverr on a mapped register");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");
	rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	match_space_a: assert property (match_pulse |=> quiet3)
		else $error("matches closer than four clocks");
	post_match_a: assert property (period_pulse |-> match_pulse)
		else $error("postscaler output without match");
endmodule

bind pmt_top pmt_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq, .match_pulse,
	.period_pulse);

`default_nettype wire

// *** period_match_timer8_test.sv ***
// self-checking bench for the period match timer over apb
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module period_match_timer8_test;
	logic        pclk, presetn, psel, penable, pwrite, er;
	logic        pready, pslverr, irq, match_pulse, period_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          errors, comparisons;

	pmt_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .irq, .match_pulse, .period_pulse);

	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end

	task check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check(pready, 1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	// cycles until the chosen pulse is sampled high
	task wait_pulse(input logic w, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((w ? period_pulse : match_pulse) !== 1'b1 && n < 3000);
	endtask

	task s_reset;
		apb(0, `PMT_OFF_COUNT, 0);
		check(rd, 8'h00);
		apb(0, `PMT_OFF_PERIOD, 0);
		check(rd, 8'hFF);
		apb(0, 12'h014, 0);
		check({er, rd}, 33'h1_0000_0000);
	endtask

	task s_regs;
		wr(`PMT_OFF_COUNT, 8'h5A);
		wr(`PMT_OFF_PERIOD, 8'hA5);
		wr(`PMT_OFF_CONTROL, 8'hFB);
		pstrb <= 4'h0;
		wr(`PMT_OFF_COUNT, 8'h11);
		pstrb <= 4'hF;
		apb(0, `PMT_OFF_CONTROL, 0);
		check(rd, 8'h7B);
		apb(0, `PMT_OFF_PERIOD, 0);
		check(rd, 8'hA5);
		repeat (40) @(posedge pclk);
		apb(0, `PMT_OFF_COUNT, 0);
		check(rd, 8'h5A);
	endtask

	task s_prescale;
		int s, n;
		wr(`PMT_OFF_COUNT, 0);
		wr(`PMT_OFF_PERIOD, 8'h02);
		for (s = 0; s < 4; s++) begin
			wr(`PMT_OFF_CONTROL, 8'h04 | s);
			wait_pulse(0, n);
			wait_pulse(0, n);
			check(n, 12 * (s == 0 ? 1 : s == 1 ? 4 : 16));
		end
	endtask

	task s_postscale;
		int f, n;
		wr(`PMT_OFF_PERIOD, 0);
		for (f = 0; f < 16; f++) begin
			wr(`PMT_OFF_CONTROL, (f << 3) | 4);
			wait_pulse(1, n);
			wait_pulse(1, n);
			check(n, 4 * (f + 1));
		end
	endtask

	// without the clear the postscaler would finish early
	task s_clear;
		int i, n, c;
		for (i = 0; i < 2; i++) begin
			wr(`PMT_OFF_CONTROL, 8'h1C);
			wait_pulse(1, n);
			wait_pulse(0, n);
			wr(i ? `PMT_OFF_CONTROL : `PMT_OFF_COUNT, i ? 8'h1C : 8'h00);
			n = 0;
			c = 0;
			do begin
				@(posedge pclk);
				n += match_pulse;
				c++;
			end while (period_pulse !== 1'b1 && c < 200);
			check(n, 4);
		end
	endtask

	task s_irq;
		int n;
		wr(`PMT_OFF_CONTROL, 0);
		wr(`PMT_OFF_FLAGS, 8'h03);
		apb(0, `PMT_OFF_FLAGS, 0);
		check(rd, 8'h00);
		wr(`PMT_OFF_MASK, 0);
		wr(`PMT_OFF_CONTROL, 8'h04);
		wait_pulse(1, n);
		wr(`PMT_OFF_CONTROL, 0);
		apb(0, `PMT_OFF_FLAGS, 0);
		check({irq, rd}, 33'h0_0000_0003);
		wr(`PMT_OFF_MASK, 8'h02);
		repeat (2) @(posedge pclk);
		check(irq, 1);
		wr(`PMT_OFF_FLAGS, 8'h02);
		repeat (2) @(posedge pclk);
		check(irq, 0);
		apb(0, `PMT_OFF_FLAGS, 0);
		check(rd, 8'h01);
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pstrb = 4'hF;
		errors = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		s_reset;
		s_regs;
		s_prescale;
		s_postscale;
		s_clear;
		s_irq;
		give_verdict;
	end

	initial begin
		repeat (40000) @(posedge pclk);
		errors++;
		give_verdict;
	end
endmodule

`default_nettype wire
